/* hsr_pkg.sv */
// Shared constants and types for the host serial register port.
// Assumes one 100 MHz clock domain and a synchronous active-high reset.
package hsr_pkg;

	// ****************************************
	// Clock and link timing
	// ****************************************
	localparam int CLK_HZ             = 100_000_000;
	localparam int SCL_MAX_HZ         = 5_000_000;
	localparam int SCL_MIN_PERIOD_CYC = CLK_HZ / SCL_MAX_HZ;

	// ****************************************
	// Register map
	// ****************************************
	localparam int       REG_CNT       = 23;
	localparam int       DET_CNT       = 15;
	localparam logic [7:0] ADR_VBP     = 8'h00;
	localparam logic [7:0] ADR_ACT_LN  = 8'h02;
	localparam logic [7:0] ADR_TOT_LN  = 8'h04;
	localparam logic [7:0] ADR_HBP     = 8'h06;
	localparam logic [7:0] ADR_ACT_PX  = 8'h08;
	localparam logic [7:0] ADR_TOT_PX  = 8'h0A;
	localparam logic [7:0] ADR_FMT     = 8'h0C;
	localparam logic [7:0] ADR_PHASE   = 8'h0D;
	localparam logic [7:0] ADR_SA_VPW  = 8'h0F;
	localparam logic [7:0] ADR_SA_VTOT = 8'h11;
	localparam logic [7:0] ADR_SA_HPW  = 8'h13;
	localparam logic [7:0] ADR_SA_HTOT = 8'h15;
	localparam logic [7:0] ADR_CTL     = 8'h29;
	localparam logic [7:0] ADR_STAT0   = 8'h2A;
	localparam logic [7:0] ADR_STAT1   = 8'h2B;
	localparam int       CTL_OVR_BIT   = 0;

	// Byte masks: unused upper bits read as zero
	localparam logic [7:0] MSK_HI11 = 8'h07;
	localparam logic [7:0] MSK_HI10 = 8'h03;
	localparam logic [7:0] MSK_FMT  = 8'h0F;
	localparam logic [7:0] MSK_FULL = 8'hFF;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Input format codes
	localparam logic [3:0] FMT_640X350  = 4'h0;
	localparam logic [3:0] FMT_1024X768 = 4'h6;
	localparam logic [3:0] FMT_USER1    = 4'h7;
	localparam logic [3:0] FMT_USER5    = 4'hB;
	localparam logic [3:0] FMT_ERR_LO   = 4'hE;

	// Target identity after reset; value is arbitrary
	localparam logic [6:0] DEV_ID_DEFAULT = 7'h2A;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [10:0] vbp;
		logic [10:0] act_lines;
		logic [10:0] tot_lines;
		logic [10:0] hbp;
		logic [10:0] act_pix;
		logic [10:0] tot_pix;
		logic [3:0]  fmt;
		logic [9:0]  phase;
	} hsr_timing_t;

	typedef struct packed {
		logic [10:0] vpw;
		logic [10:0] vtot;
		logic [10:0] hpw;
		logic [10:0] htot;
	} hsr_standalone_t;

	typedef struct packed {
		logic [7:0] err_flags;
		logic [3:0] calib_state;
	} hsr_status_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_REG, ST_ACK_REG,
		ST_WDATA, ST_ACK_DATA, ST_RDATA, ST_RACK
	} hsr_state_t;

endpackage : hsr_pkg

/* hsr_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the clock of the consuming domain and its synchronous reset.
`timescale 1ns/1ps
module hsr_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Pins in, synchronised levels out
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] d_out
);

	logic [W-1:0] meta_r;

	// ****************************************
	// One two-stage chain per bit
	// ****************************************
	for (genvar i = 0; i < W; i++) begin : g_bit
		// Idle bus level is high, so reset to one
		always_ff @(posedge clock) begin
			if (rst) begin
				meta_r[i] <= 1'b1;
				d_out[i]  <= 1'b1;
			end else begin
				meta_r[i] <= d_in[i];
				d_out[i]  <= meta_r[i];
			end
		end
	end

endmodule : hsr_sync

/* hsr_top.sv */
// Two-wire serial target port giving a host access to timing registers.
// Assumes detection, calibration and identity sources on the same clock.
//
// What this block does
// - Serial clock up to 5 MHz is accepted; host never exceeds it.
// - Data line is shared: host drives address and writes, device read data.
// - Single and sequential register writes are supported.
// - Single and sequential register reads are supported.
// - Seven-bit identity has a default, replaceable from the stored identity entry.
// - Host writes land in shadow registers, copied while override is set.
// - Override set suspends automatic mode detection and calibration.
// - Reads return live state including detection and phase results.
// - Host writes can disable automatic features and force a chosen state.
// - Output size and position follow programmed porches and counts.
// - No input or out-of-range input selects four standalone timing registers.
// - 11-bit vertical back porch at bytes 0-1.
// - 11-bit active lines at bytes 2-3.
// - 11-bit total lines at bytes 4-5.
// - 11-bit horizontal back porch at bytes 6-7.
// - 11-bit active pixels at bytes 8-9.
// - 11-bit total pixels at bytes A-B.
// - 4-bit format code at C: seven resolutions, then user modes 1-4.
// - Codes 11-13 are user modes 5-7, codes 14-15 flag error.
// - Override clear: device writes, host reads; set: only host writes.
`timescale 1ns/1ps
module hsr_top (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst,
	// Serial link pins
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe_n,
	// Device-side detection and status
	input  wire hsr_pkg::hsr_timing_t     det,
	input  wire logic                     det_load,
	input  wire hsr_pkg::hsr_status_t     status,
	input  wire logic                     no_input,
	input  wire logic                     out_of_range,
	// Identity reload from stored configuration
	input  wire logic                     id_load,
	input  wire logic [6:0]               id_value,
	// Working values and modes
	output hsr_pkg::hsr_timing_t          timing,
	output hsr_pkg::hsr_standalone_t      standalone,
	output logic                          standalone_sel,
	output logic                          auto_suspend,
	output logic                          fmt_error
);

	// ****************************************
	// Declarations
	// ****************************************
	logic              scl_s;
	logic              sda_s;
	logic              scl_q_r;
	logic              sda_q_r;
	logic              start_ev;
	logic              stop_ev;
	logic              scl_rise;
	logic              scl_fall;

	hsr_pkg::hsr_state_t st_r, st_nxt;
	logic [2:0]        cnt_r, cnt_nxt;
	logic [7:0]        sh_r, sh_nxt;
	logic              bdone_r, bdone_nxt;
	logic              rw_r, rw_nxt;
	logic [7:0]        ptr_r, ptr_nxt;
	logic              oe_n_r, oe_n_nxt;
	logic              mack_r, mack_nxt;
	logic              wr_en;
	logic [7:0]        rd_byte;

	logic [7:0]        work_r [hsr_pkg::REG_CNT];
	logic [7:0]        work_nxt [hsr_pkg::REG_CNT];
	logic [7:0]        shd_r [hsr_pkg::REG_CNT];
	logic [7:0]        shd_nxt [hsr_pkg::REG_CNT];
	logic [7:0]        det_img [hsr_pkg::DET_CNT];
	logic              ovr_r, ovr_nxt;
	logic [6:0]        id_r, id_nxt;
	logic              sa_sel_r;
	logic              fmt_err_r;

	// ****************************************
	// Byte layout helpers
	// ****************************************
	// Mask of implemented bits for each byte of the map
	function automatic logic [7:0] byte_mask(input logic [7:0] a);
		logic [7:0] m;
		m = hsr_pkg::MSK_FULL;
		if (a < hsr_pkg::ADR_FMT) begin
			m = a[0] ? hsr_pkg::MSK_FULL : hsr_pkg::MSK_HI11;
		end else if (a == hsr_pkg::ADR_FMT) begin
			m = hsr_pkg::MSK_FMT;
		end else if (a == hsr_pkg::ADR_PHASE) begin
			m = hsr_pkg::MSK_HI10;
		end else if (a >= hsr_pkg::ADR_SA_VPW) begin
			m = a[0] ? hsr_pkg::MSK_HI11 : hsr_pkg::MSK_FULL;
		end
		return m;
	endfunction : byte_mask

	// Upper byte of an 11-bit field
	function automatic logic [7:0] hi11(input logic [10:0] f);
		return {5'h00, f[10:8]};
	endfunction : hi11

	// ****************************************
	// Pin synchronisation and bus events
	// ****************************************
	// Link pins cross into the core clock first
	hsr_sync #(
		.W(2)
	) u_sync (
		.clock(clock),
		.rst  (rst),
		.d_in ({scl_in, sda_in}),
		.d_out({scl_s, sda_s})
	);

	// Previous synchronised levels for edge detection
	always_ff @(posedge clock) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
		end
	end

	// Start and stop are data edges while the host holds clock high
	assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_ev  = scl_s & scl_q_r & ~sda_q_r & sda_s;
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;

	// ****************************************
	// Read data selection
	// ****************************************
	// Live working values and status; unmapped addresses read zero
	always_comb begin
		rd_byte = hsr_pkg::RST_BYTE;
		if (ptr_r < 8'(hsr_pkg::REG_CNT)) begin
			rd_byte = work_r[ptr_r[4:0]];
		end else if (ptr_r == hsr_pkg::ADR_CTL) begin
			rd_byte = {7'h00, ovr_r};
		end else if (ptr_r == hsr_pkg::ADR_STAT0) begin
			rd_byte = status.err_flags;
		end else if (ptr_r == hsr_pkg::ADR_STAT1) begin
			rd_byte = {4'h0, status.calib_state};
		end
	end

	// ****************************************
	// Serial protocol engine
	// ****************************************
	// Byte framing, address match, acknowledge and data direction
	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		bdone_nxt = bdone_r;
		rw_nxt    = rw_r;
		ptr_nxt   = ptr_r;
		oe_n_nxt  = oe_n_r;
		mack_nxt  = mack_r;
		wr_en     = 1'b0;
		if (stop_ev) begin
			st_nxt   = hsr_pkg::ST_IDLE;
			oe_n_nxt = 1'b1;
		end else if (start_ev) begin
			// Repeated start keeps the pointer for random reads
			st_nxt    = hsr_pkg::ST_ADDR;
			cnt_nxt   = 3'h0;
			bdone_nxt = 1'b0;
			oe_n_nxt  = 1'b1;
		end else if (scl_rise) begin
			unique case (st_r)
				hsr_pkg::ST_ADDR, hsr_pkg::ST_REG, hsr_pkg::ST_WDATA: begin
					sh_nxt    = {sh_r[6:0], sda_s};
					cnt_nxt   = cnt_r + 3'h1;
					bdone_nxt = (cnt_r == 3'h7);
				end
				hsr_pkg::ST_RDATA: begin
					cnt_nxt   = cnt_r + 3'h1;
					bdone_nxt = (cnt_r == 3'h7);
				end
				hsr_pkg::ST_RACK: begin
					mack_nxt = ~sda_s;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (st_r)
				hsr_pkg::ST_ADDR: begin
					if (bdone_r) begin
						bdone_nxt = 1'b0;
						if (sh_r[7:1] == id_r) begin
							rw_nxt   = sh_r[0];
							oe_n_nxt = 1'b0;
							st_nxt   = hsr_pkg::ST_ACK_ADDR;
						end else begin
							st_nxt = hsr_pkg::ST_IDLE;
						end
					end
				end
				hsr_pkg::ST_ACK_ADDR: begin
					oe_n_nxt = 1'b1;
					cnt_nxt  = 3'h0;
					if (rw_r) begin
						// Device takes the data line for read data
						sh_nxt   = rd_byte;
						oe_n_nxt = rd_byte[7];
						st_nxt   = hsr_pkg::ST_RDATA;
					end else begin
						st_nxt = hsr_pkg::ST_REG;
					end
				end
				hsr_pkg::ST_REG: begin
					if (bdone_r) begin
						bdone_nxt = 1'b0;
						ptr_nxt   = sh_r;
						oe_n_nxt  = 1'b0;
						st_nxt    = hsr_pkg::ST_ACK_REG;
					end
				end
				hsr_pkg::ST_ACK_REG, hsr_pkg::ST_ACK_DATA: begin
					oe_n_nxt = 1'b1;
					cnt_nxt  = 3'h0;
					st_nxt   = hsr_pkg::ST_WDATA;
				end
				hsr_pkg::ST_WDATA: begin
					if (bdone_r) begin
						bdone_nxt = 1'b0;
						wr_en     = 1'b1;
						ptr_nxt   = ptr_r + 8'h01;
						oe_n_nxt  = 1'b0;
						st_nxt    = hsr_pkg::ST_ACK_DATA;
					end
				end
				hsr_pkg::ST_RDATA: begin
					if (bdone_r) begin
						bdone_nxt = 1'b0;
						oe_n_nxt  = 1'b1;
						ptr_nxt   = ptr_r + 8'h01;
						st_nxt    = hsr_pkg::ST_RACK;
					end else begin
						sh_nxt   = {sh_r[6:0], 1'b0};
						oe_n_nxt = sh_r[6];
					end
				end
				hsr_pkg::ST_RACK: begin
					cnt_nxt = 3'h0;
					if (mack_r) begin
						// Host acknowledged: send the next byte
						sh_nxt   = rd_byte;
						oe_n_nxt = rd_byte[7];
						st_nxt   = hsr_pkg::ST_RDATA;
					end else begin
						st_nxt = hsr_pkg::ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// Detection results laid out as register bytes
	always_comb begin
		det_img[0]  = hi11(det.vbp);
		det_img[1]  = det.vbp[7:0];
		det_img[2]  = hi11(det.act_lines);
		det_img[3]  = det.act_lines[7:0];
		det_img[4]  = hi11(det.tot_lines);
		det_img[5]  = det.tot_lines[7:0];
		det_img[6]  = hi11(det.hbp);
		det_img[7]  = det.hbp[7:0];
		det_img[8]  = hi11(det.act_pix);
		det_img[9]  = det.act_pix[7:0];
		det_img[10] = hi11(det.tot_pix);
		det_img[11] = det.tot_pix[7:0];
		det_img[12] = {4'h0, det.fmt};
		det_img[13] = {6'h00, det.phase[9:8]};
		det_img[14] = det.phase[7:0];
	end

	// Shadow capture, override copy and device updates
	always_comb begin
		for (int i = 0; i < hsr_pkg::REG_CNT; i++) begin
			work_nxt[i] = work_r[i];
			shd_nxt[i]  = shd_r[i];
		end
		ovr_nxt = ovr_r;
		id_nxt  = id_r;
		if (wr_en) begin
			if (ptr_r < 8'(hsr_pkg::REG_CNT)) begin
				shd_nxt[ptr_r[4:0]] = sh_r & byte_mask(ptr_r);
			end else if (ptr_r == hsr_pkg::ADR_CTL) begin
				ovr_nxt = sh_r[hsr_pkg::CTL_OVR_BIT];
			end
		end
		if (ovr_r) begin
			// Host owns the working values; device updates are dropped
			for (int i = 0; i < hsr_pkg::REG_CNT; i++) begin
				work_nxt[i] = shd_r[i];
			end
		end else if (det_load) begin
			for (int i = 0; i < hsr_pkg::DET_CNT; i++) begin
				work_nxt[i] = det_img[i];
			end
		end
		if (id_load) begin
			id_nxt = id_value;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	// Protocol, register file and derived mode flags
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r      <= hsr_pkg::ST_IDLE;
			cnt_r     <= 3'h0;
			sh_r      <= 8'h00;
			bdone_r   <= 1'b0;
			rw_r      <= 1'b0;
			ptr_r     <= 8'h00;
			oe_n_r    <= 1'b1;
			mack_r    <= 1'b0;
			ovr_r     <= 1'b0;
			id_r      <= hsr_pkg::DEV_ID_DEFAULT;
			sa_sel_r  <= 1'b0;
			fmt_err_r <= 1'b0;
			for (int i = 0; i < hsr_pkg::REG_CNT; i++) begin
				work_r[i] <= hsr_pkg::RST_BYTE;
				shd_r[i]  <= hsr_pkg::RST_BYTE;
			end
		end else begin
			st_r      <= st_nxt;
			cnt_r     <= cnt_nxt;
			sh_r      <= sh_nxt;
			bdone_r   <= bdone_nxt;
			rw_r      <= rw_nxt;
			ptr_r     <= ptr_nxt;
			oe_n_r    <= oe_n_nxt;
			mack_r    <= mack_nxt;
			ovr_r     <= ovr_nxt;
			id_r      <= id_nxt;
			sa_sel_r  <= no_input | out_of_range;
			fmt_err_r <= (work_nxt[12][3:0] >= hsr_pkg::FMT_ERR_LO);
			for (int i = 0; i < hsr_pkg::REG_CNT; i++) begin
				work_r[i] <= work_nxt[i];
				shd_r[i]  <= shd_nxt[i];
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Open-drain data: only ever pulls low
	assign sda_out        = 1'b0;
	assign sda_oe_n       = oe_n_r;
	assign auto_suspend   = ovr_r;
	assign standalone_sel = sa_sel_r;
	assign fmt_error      = fmt_err_r;

	// Working fields steer picture size and position
	assign timing.vbp       = {work_r[0][2:0], work_r[1]};
	assign timing.act_lines = {work_r[2][2:0], work_r[3]};
	assign timing.tot_lines = {work_r[4][2:0], work_r[5]};
	assign timing.hbp       = {work_r[6][2:0], work_r[7]};
	assign timing.act_pix   = {work_r[8][2:0], work_r[9]};
	assign timing.tot_pix   = {work_r[10][2:0], work_r[11]};
	assign timing.fmt       = work_r[12][3:0];
	assign timing.phase     = {work_r[13][1:0], work_r[14]};

	// Standalone timing, upper bits at the lower address
	assign standalone.vpw  = {work_r[15][2:0], work_r[16]};
	assign standalone.vtot = {work_r[17][2:0], work_r[18]};
	assign standalone.hpw  = {work_r[19][2:0], work_r[20]};
	assign standalone.htot = {work_r[21][2:0], work_r[22]};

endmodule : hsr_top

/* hsr_top_asserts.sv */
// Checker for the host serial register port, attached to the top by bind.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module hsr_top_asserts (
	// Clock and reset
	input wire logic                     clock,
	input wire logic                     rst,
	// Link pins
	input wire logic                     scl_in,
	input wire logic                     sda_in,
	input wire logic                     sda_out,
	input wire logic                     sda_oe_n,
	// Device side
	input wire hsr_pkg::hsr_timing_t     det,
	input wire logic                     det_load,
	input wire hsr_pkg::hsr_status_t     status,
	input wire logic                     no_input,
	input wire logic                     out_of_range,
	input wire logic                     id_load,
	input wire logic [6:0]               id_value,
	// Working values
	input wire hsr_pkg::hsr_timing_t     timing,
	input wire hsr_pkg::hsr_standalone_t standalone,
	input wire logic                     standalone_sel,
	input wire logic                     auto_suspend,
	input wire logic                     fmt_error
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_sda_low_only: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_reset_idle: assert property (disable iff (1'b0)
		rst |=> sda_oe_n && !auto_suspend && timing == '0)
		else $error("reset left the port active");
	a_drive_on_fall: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data line taken while serial clock high");
	a_sel_set: assert property ((no_input || out_of_range) |=> standalone_sel)
		else $error("standalone not selected");
	a_sel_clear: assert property (!(no_input || out_of_range) |=> !standalone_sel)
		else $error("standalone selected without cause");
	a_fmt_err_set: assert property (timing.fmt >= 4'hE |-> ##[0:1] fmt_error)
		else $error("error format code not flagged");
	a_fmt_err_clear: assert property (
		timing.fmt < 4'hE && $past(timing.fmt) < 4'hE |-> !fmt_error)
		else $error("format error flagged on valid code");
	a_det_copy: assert property (
		det_load && !auto_suspend |-> ##[1:2] timing == det)
		else $error("detection result not loaded");
	a_det_ignored: assert property (
		det_load && auto_suspend && timing != det |=> timing != det ##1 timing != det)
		else $error("detection overwrote host values");
	a_susp_on_fall: assert property ($changed(auto_suspend) |-> !scl_in)
		else $error("override changed outside a write");
	a_timing_cause: assert property (
		$changed(timing) |-> !scl_in || $past(det_load) || $past(det_load, 2))
		else $error("working values changed without cause");

	// Main scenarios reached
	c_det_load: cover property (det_load && !auto_suspend);
	c_drive: cover property ($fell(sda_oe_n));
	c_fmt_err: cover property ($rose(fmt_error));
endmodule : hsr_top_asserts

bind hsr_top hsr_top_asserts hsr_top_asserts_i (.clock, .rst, .scl_in, .sda_in, .sda_out,
	.sda_oe_n, .det, .det_load, .status, .no_input, .out_of_range, .id_load, .id_value,
	.timing, .standalone, .standalone_sel, .auto_suspend, .fmt_error);

/* hsr_host_model.sv */
// Behavioural two-wire host that masters the serial register port.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ps
module hsr_host_model (
	// Clock
	input wire logic  clock,
	// Link wires
	output logic      scl,
	output logic      sda_h,
	input wire logic  sda
);
	// Idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask : wt
	// One bit, 200 ns period: 5 MHz at most, low and high 10 cycles each
	task automatic bit_x(input logic b, output logic r);
		sda_h = b;
		wt(5);
		scl = 1'b1;
		wt(5);
		r = sda;
		wt(5);
		scl = 1'b0;
		wt(5);
	endtask : bit_x
	// Eight bits, most significant first
	task automatic byte_x(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
	endtask : byte_x
	// Start or repeated start, data falls while clock high
	task automatic start();
		sda_h = 1'b1;
		wt(5);
		scl = 1'b1;
		wt(5);
		sda_h = 1'b0;
		wt(5);
		scl = 1'b0;
		wt(5);
	endtask : start
	// Stop, data rises while clock high
	task automatic stop();
		sda_h = 1'b0;
		wt(5);
		scl = 1'b1;
		wt(5);
		sda_h = 1'b1;
		wt(10);
	endtask : stop
	// Pointer then n bytes written, or read after repeated start
	task automatic xfer(input logic [6:0] id, input logic [7:0] a, input logic rnw,
		input int n, inout logic [31:0] d, output logic ok);
		logic [7:0] r;
		logic       k;
		ok = 1'b1;
		start();
		byte_x({id, 1'b0}, r);
		bit_x(1'b1, k);
		ok = ok & ~k;
		byte_x(a, r);
		bit_x(1'b1, k);
		ok = ok & ~k;
		if (rnw) begin
			start();
			byte_x({id, 1'b1}, r);
			bit_x(1'b1, k);
			ok = ok & ~k;
		end
		for (int i = 0; i < n; i++) begin
			byte_x(rnw ? 8'hFF : d[8*i+:8], r);
			if (rnw) begin
				d[8*i+:8] = r;
			end
			bit_x(rnw ? (i == n - 1) : 1'b1, k); // Host refuses the last read byte
			ok = ok & (rnw | ~k);
		end
		stop();
	endtask : xfer
endmodule : hsr_host_model

/* host_serial_register_port_tb.sv */
// Self-checking bench for the host serial register port.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module host_serial_register_port_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic                     clock;
	logic                     rst;
	logic                     scl;
	logic                     sda_h;
	logic                     sda;
	logic                     sda_out;
	logic                     sda_oe_n;
	hsr_pkg::hsr_timing_t     det;
	logic                     det_load;
	hsr_pkg::hsr_status_t     status;
	logic                     no_input;
	logic                     out_of_range;
	logic                     id_load;
	logic [6:0]               id_value;
	hsr_pkg::hsr_timing_t     timing;
	hsr_pkg::hsr_standalone_t standalone;
	logic                     standalone_sel;
	logic                     auto_suspend;
	logic                     fmt_error;
	logic [6:0]               id;
	logic                     ok;
	logic [31:0]              rv;
	int                       fail_count;
	int                       cmp_count;
	int                       cyc = 0;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] w;
		logic [7:0] e;
	} hsr_row_t;
	hsr_row_t                 rows [8];

	// Open-drain data wire with pull-up
	assign sda = sda_h & (sda_oe_n | sda_out);

	// Clock, 10 ns period
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	hsr_top hsr_top_i (.clock, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
		.det, .det_load, .status, .no_input, .out_of_range, .id_load, .id_value,
		.timing, .standalone, .standalone_sel, .auto_suspend, .fmt_error);
	hsr_host_model hsr_host_model_i (.clock, .scl, .sda_h, .sda);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [95:0] s, input logic [95:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
		hsr_host_model_i.xfer(id, a, 1'b0, n, d, ok);
	endtask : wr
	task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d);
		d = '0;
		hsr_host_model_i.xfer(id, a, 1'b1, n, d, ok);
	endtask : rd
	task automatic pulse();
		det_load = 1'b1;
		@(negedge clock);
		det_load = 1'b0;
		repeat (3) @(negedge clock);
	endtask : pulse
	task automatic test_done();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			test_done();
		end
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{rst, det_load, no_input, out_of_range, id_load} = 5'h10;
		det = '0;
		status = '0;
		id_value = 7'h00;
		id = hsr_pkg::DEV_ID_DEFAULT;
		{fail_count, cmp_count} = '0;
		rows = '{'{8'h00, 8'hFF, 8'h07}, '{8'h01, 8'h5A, 8'h5A}, '{8'h04, 8'hFA, 8'h02},
			'{8'h05, 8'h11, 8'h11}, '{8'h0A, 8'h06, 8'h06}, '{8'h0B, 8'h99, 8'h99},
			'{8'h0C, 8'hF3, 8'h03}, '{8'h0D, 8'hFF, 8'h03}};
		repeat (10) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		chk(timing, '0);
		chk({auto_suspend, sda_oe_n, fmt_error, standalone}, {3'b010, 44'h0});
		// Shadow write hidden until override is set
		wr(hsr_pkg::ADR_ACT_LN, 32'h05, 1);
		chk(timing.act_lines, 11'h000);
		wr(hsr_pkg::ADR_CTL, 32'h01, 1);
		chk(auto_suspend, 1'b1);
		chk(timing.act_lines, 11'h500);
		// Single writes read back through the map
		foreach (rows[i]) begin
			wr(rows[i].a, {24'h0, rows[i].w}, 1);
			rd(rows[i].a, 1, rv);
			chk(rv[7:0], rows[i].e);
		end
		chk({timing.vbp, timing.tot_lines, timing.tot_pix}, {11'h75A, 11'h211, 11'h699});
		chk(timing.fmt, 4'h3);
		// Sequential write then sequential read
		wr(hsr_pkg::ADR_HBP, 32'h56042301, 4);
		rd(hsr_pkg::ADR_HBP, 4, rv);
		chk(rv, 32'h56042301);
		chk({timing.hbp, timing.act_pix}, {11'h123, 11'h456});
		// Standalone field, upper bits first
		wr(hsr_pkg::ADR_SA_VPW, 32'h34FF, 2);
		chk(standalone.vpw, 11'h734);
		// Every format code, error flag on the last two
		for (int c = 0; c < 16; c++) begin
			wr(hsr_pkg::ADR_FMT, 32'(c), 1);
			chk(fmt_error, c >= 14);
		end
		// Detection refused under override, loaded once released
		det = {11'h321, 11'h2AB, 11'h432, 11'h0C5, 11'h3DE, 11'h5F0, 4'h9, 10'h1E7};
		pulse();
		chk(timing.tot_lines, 11'h211);
		wr(hsr_pkg::ADR_CTL, 32'h00, 1);
		chk(auto_suspend, 1'b0);
		pulse();
		chk(timing, det);
		rd(hsr_pkg::ADR_TOT_LN, 2, rv);
		chk(rv[15:0], 16'h3204);
		// Status read-only, unmapped reads zero
		status = '{err_flags: 8'hA5, calib_state: 4'hC};
		wr(hsr_pkg::ADR_STAT0, 32'h00, 1);
		rd(hsr_pkg::ADR_STAT0, 2, rv);
		chk(rv[15:0], 16'h0CA5);
		rd(8'h30, 1, rv);
		chk(rv[7:0], 8'h00);
		// Foreign identity refused, reloaded identity answered
		hsr_host_model_i.xfer(7'h55, 8'h00, 1'b1, 1, rv, ok);
		chk(ok, 1'b0);
		id_value = 7'h33;
		id_load = 1'b1;
		@(negedge clock);
		id_load = 1'b0;
		id = 7'h33;
		rd(hsr_pkg::ADR_STAT0, 1, rv);
		chk({ok, rv[7:0]}, {1'b1, 8'hA5});
		// Standalone selection from each cause
		for (int k = 3; k >= 0; k--) begin
			{no_input, out_of_range} = 2'(k);
			repeat (2) @(negedge clock);
			chk(standalone_sel, k != 0);
		end
		// Mid-run reset clears working values and override
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		chk({timing, auto_suspend, sda_oe_n}, {81'h0, 1'b1});
		test_done();
	end
endmodule : host_serial_register_port_tb
